// ### core/dsc_consts.vh
`ifndef DSC_CONSTS_VH
`define DSC_CONSTS_VH

// Clock and protection timing
`define DSC_CLK_HZ 25000000
`define DSC_OFF_MS 900
`define DSC_ON_MS 20
`define DSC_OFF_CYC (`DSC_OFF_MS * (`DSC_CLK_HZ / 1000))
`define DSC_ON_CYC (`DSC_ON_MS * (`DSC_CLK_HZ / 1000))

// Slave address, upper six bits; the strap supplies bit 0
`define DSC_ADDR_HI 6'h04

// Register reset value
`define DSC_REG_RST 8'h00

// Channel one register fields
`define DSC_C1_SEL 7
`define DSC_C1_DYN_DIS 6
`define DSC_C1_CUR_SEL 5
`define DSC_C1_TONE 4
`define DSC_C1_CABLE 3
`define DSC_C1_VOLT 2
`define DSC_C1_ON 1
`define DSC_C1_OLF 0

// Channel two register fields
`define DSC_C2_SEL 7
`define DSC_C2_CUR_SEL 6
`define DSC_C2_TONE 5
`define DSC_C2_CABLE 4
`define DSC_C2_VOLT 3
`define DSC_C2_ON 2
`define DSC_C2_OTF 1
`define DSC_C2_OLF 0

// Write masks of the software-owned bits
`define DSC_C1_WMASK 8'hFE
`define DSC_C2_WMASK 8'hFC

`endif

// ### core/dsc_control.v
// How it works
// RULE_01: Each channel's current_limit_select bit picks low or high overload threshold.
// RULE_02: Dynamic mode: overload turns the channel off for the off_interval.
// RULE_03: Dynamic mode sets overload_flag when the overload shutdown begins.
// RULE_04: After off_interval the output returns for on_interval, current clamped.
// RULE_05: Overload still present at end of on_interval repeats the off/on cycle.
// RULE_06: A clean on_interval returns to normal and clears overload_flag.
// RULE_07: Static mode: overload_flag follows the clamp-reached condition.
// RULE_08: overload_flag is zero after reset and power-up.
// RULE_09: Host may start capacitive loads in static mode, then go dynamic.
// RULE_10: Over-temperature shuts both channels off and sets overtemp_flag until cooled.
// RULE_11: Over-temperature clears the writable configuration bits of both registers.
// RULE_12: Host polls enable bits and overtemp_flag and rewrites cleared configuration.
// RULE_13: High-voltage pin lifts the register level by five volts.
// RULE_14: Host using the high-voltage pin programs the 13V register setting.
// RULE_15: Serial slave works at standard and fast rates, SDA open-drain only.
// RULE_16: SDA driven only changes while SCL is low.
// RULE_17: START is SDA falling with SCL high, STOP is SDA rising.
// RULE_18: Bytes are eight bits, MSB first, each followed by an acknowledge.
// RULE_19: Addressed device pulls SDA low for the whole ninth clock.
// RULE_20: No acknowledge while supply_good is low.
// RULE_21: Transaction is START, address with read/write bit, data, STOP.
// RULE_22: Both registers reset to zero; field order as laid out in header.
// RULE_23: With supply_good low, traffic is ignored and registers held at zero.
// RULE_24: Address strap selects slave address 0001000 or 0001001.
// RULE_25: Reads return register bytes MSB first until master withholds acknowledge.
// RULE_26: Written byte goes to channel two when its MSB is one.
// RULE_27: Off and on intervals are counted on the internal clock.
`timescale 1ns/1ps
`include "dsc_consts.vh"

module dsc_control #(
  parameter OFF_CYC = `DSC_OFF_CYC,
  parameter ON_CYC = `DSC_ON_CYC
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_supply_good,
  input wire i_scl,
  input wire i_sda,
  input wire i_addr_strap,
  input wire i_overtemp,
  input wire [1:0] i_overload,
  input wire [1:0] i_high_volt_pin,
  output wire o_sda_out,
  output reg o_sda_oe_n,
  output wire [1:0] o_power_on,
  output reg [1:0] o_limit_high,
  output reg [1:0] o_tone_force,
  output reg [1:0] o_volt_ch1,
  output reg [1:0] o_volt_ch2,
  output reg [7:0] o_channel_one_config,
  output reg [7:0] o_channel_two_config
);

  localparam [2:0] ST_IDLE = 3'd0;
  localparam [2:0] ST_ADDR = 3'd1;
  localparam [2:0] ST_ADDR_ACK = 3'd2;
  localparam [2:0] ST_WR_DATA = 3'd3;
  localparam [2:0] ST_WR_ACK = 3'd4;
  localparam [2:0] ST_RD_DATA = 3'd5;
  localparam [2:0] ST_RD_ACK = 3'd6;

  // =====================================
  // Input synchronisers
  // Pins are async to i_clk; first stages feed only the second stages
  reg [8:0] sync_a;
  reg [8:0] sync_b;
  reg scl_prev;
  reg sda_prev;
  wire [8:0] pins_in;

  assign pins_in = {i_supply_good, i_high_volt_pin, i_overload, i_overtemp, i_addr_strap, i_sda, i_scl};

  always @(posedge i_clk)
  begin
    if (!i_resetn)
    begin
      sync_a <= 9'h003;
      sync_b <= 9'h003;
      scl_prev <= 1'b1;
      sda_prev <= 1'b1;
    end
    else
    begin
      sync_a <= pins_in;
      sync_b <= sync_a;
      scl_prev <= sync_b[0];
      sda_prev <= sync_b[1];
    end
  end

  wire scl = sync_b[0];
  wire sda = sync_b[1];
  wire strap = sync_b[2];
  wire hot = sync_b[3];
  wire [1:0] ovl = sync_b[5:4];
  wire [1:0] hvp = sync_b[7:6];
  // Supply-good low acts as a reset of all control logic past the input synchronisers
  wire rst = !i_resetn || !sync_b[8]; // RULE_23
  wire scl_rise = scl && !scl_prev;
  wire scl_fall = !scl && scl_prev;
  wire start_seen = scl && scl_prev && sda_prev && !sda; // RULE_17
  wire stop_seen = scl && scl_prev && !sda_prev && sda; // RULE_17

  // =====================================
  // Serial slave
  reg [2:0] state;
  reg [2:0] bit_cnt;
  reg byte_done;
  reg [7:0] shift;
  reg [7:0] tx;
  reg rd_sel;
  reg rw;
  reg wr_stb;
  reg [7:0] wr_byte;
  wire [6:0] my_addr = {`DSC_ADDR_HI, strap}; // RULE_24
  always @(posedge i_clk)
  begin
    if (rst)
    begin
      state <= ST_IDLE;
      bit_cnt <= 3'd0;
      byte_done <= 1'b0;
      shift <= 8'h00;
      tx <= 8'h00;
      rd_sel <= 1'b0;
      rw <= 1'b0;
      wr_stb <= 1'b0;
      wr_byte <= 8'h00;
      o_sda_oe_n <= 1'b1;
    end
    else
    begin
      wr_stb <= 1'b0;
      if (start_seen)
      begin
        state <= ST_ADDR; // RULE_21
        bit_cnt <= 3'd0;
        byte_done <= 1'b0;
        rd_sel <= 1'b0;
        o_sda_oe_n <= 1'b1;
      end
      else if (stop_seen)
      begin
        state <= ST_IDLE;
        o_sda_oe_n <= 1'b1;
      end
      else
      begin
        case (state)
          ST_ADDR, ST_WR_DATA:
          begin
            if (scl_rise)
            begin
              shift <= {shift[6:0], sda}; // RULE_18
              bit_cnt <= bit_cnt + 3'd1;
              byte_done <= (bit_cnt == 3'd7);
            end
            else if (scl_fall && byte_done)
            begin
              byte_done <= 1'b0;
              if (state == ST_ADDR)
              begin
                if (shift[7:1] == my_addr)
                begin
                  rw <= shift[0];
                  o_sda_oe_n <= 1'b0; // RULE_19 RULE_20
                  state <= ST_ADDR_ACK;
                end
                else
                  state <= ST_IDLE;
              end
              else
              begin
                wr_byte <= shift;
                wr_stb <= 1'b1;
                o_sda_oe_n <= 1'b0; // RULE_19
                state <= ST_WR_ACK;
              end
            end
          end
          ST_ADDR_ACK, ST_WR_ACK:
          begin
            if (scl_fall)
            begin
              bit_cnt <= 3'd0;
              if (state == ST_ADDR_ACK && rw)
              begin
                tx <= {o_channel_one_config[6:0], 1'b0};
                o_sda_oe_n <= o_channel_one_config[7]; // RULE_25 RULE_16
                rd_sel <= 1'b1;
                state <= ST_RD_DATA;
              end
              else
              begin
                o_sda_oe_n <= 1'b1;
                state <= ST_WR_DATA;
              end
            end
          end
          ST_RD_DATA:
          begin
            if (scl_rise)
            begin
              bit_cnt <= bit_cnt + 3'd1;
              byte_done <= (bit_cnt == 3'd7);
            end
            else if (scl_fall)
            begin
              if (byte_done)
              begin
                byte_done <= 1'b0;
                o_sda_oe_n <= 1'b1;
                state <= ST_RD_ACK;
              end
              else
              begin
                o_sda_oe_n <= tx[7]; // RULE_16
                tx <= {tx[6:0], 1'b0};
              end
            end
          end
          ST_RD_ACK:
          begin
            if (scl_rise)
            begin
              // Master's acknowledge decides whether another byte follows
              if (sda)
                state <= ST_IDLE; // RULE_25
              else
                byte_done <= 1'b1;
            end
            else if (scl_fall && byte_done)
            begin
              byte_done <= 1'b0;
              bit_cnt <= 3'd0;
              rd_sel <= !rd_sel;
              if (rd_sel)
              begin
                o_sda_oe_n <= o_channel_two_config[7];
                tx <= {o_channel_two_config[6:0], 1'b0};
              end
              else
              begin
                o_sda_oe_n <= o_channel_one_config[7];
                tx <= {o_channel_one_config[6:0], 1'b0};
              end
              state <= ST_RD_DATA;
            end
          end
          default: state <= ST_IDLE;
        endcase
      end
    end
  end

  // Open drain: the pin is only ever pulled low
  assign o_sda_out = 1'b0; // RULE_15

  // =====================================
  // System registers
  wire [1:0] overload_flag;
  wire [7:0] wmask1 = `DSC_C1_WMASK;
  wire [7:0] wmask2 = `DSC_C2_WMASK;

  always @(posedge i_clk)
  begin
    if (rst)
    begin
      o_channel_one_config <= `DSC_REG_RST; // RULE_22
      o_channel_two_config <= `DSC_REG_RST; // RULE_22
    end
    else
    begin
      // Heat wins over a write landing in the same cycle
      if (hot)
        o_channel_one_config[7:1] <= 7'h00; // RULE_11
      else if (wr_stb && !wr_byte[7])
        o_channel_one_config[7:1] <= wr_byte[7:1] & wmask1[7:1]; // RULE_26
      if (hot)
        o_channel_two_config[7:2] <= 6'h00; // RULE_11
      else if (wr_stb && wr_byte[7])
        o_channel_two_config[7:2] <= wr_byte[7:2] & wmask2[7:2]; // RULE_26
      o_channel_one_config[`DSC_C1_OLF] <= overload_flag[0];
      o_channel_two_config[`DSC_C2_OLF] <= overload_flag[1];
      o_channel_two_config[`DSC_C2_OTF] <= hot; // RULE_10
    end
  end

  // =====================================
  // Per-channel protection and output selection
  wire [1:0] ch_on = {o_channel_two_config[`DSC_C2_ON], o_channel_one_config[`DSC_C1_ON]};
  wire [1:0] cur_sel = {o_channel_two_config[`DSC_C2_CUR_SEL], o_channel_one_config[`DSC_C1_CUR_SEL]};
  wire [1:0] tone = {o_channel_two_config[`DSC_C2_TONE], o_channel_one_config[`DSC_C1_TONE]};
  wire [1:0] cable = {o_channel_two_config[`DSC_C2_CABLE], o_channel_one_config[`DSC_C1_CABLE]};
  wire [1:0] vsel = {o_channel_two_config[`DSC_C2_VOLT], o_channel_one_config[`DSC_C1_VOLT]};
  // Only the first register carries the mode bit; it governs both channels
  wire dyn_dis = o_channel_one_config[`DSC_C1_DYN_DIS];

  genvar g;
  generate
    for (g = 0; g < 2; g = g + 1)
    begin : g_chan
      dsc_overload #(
        .OFF_CYC(OFF_CYC),
        .ON_CYC(ON_CYC)
      ) u_ovl (
        .i_clk(i_clk),
        .i_rst(rst),
        .i_enable(ch_on[g] && !hot), // RULE_10
        .i_dyn_disable(dyn_dis),
        .i_overload(ovl[g]),
        .o_power_on(o_power_on[g]),
        .o_flag(overload_flag[g])
      );
    end
  endgenerate

  // Level code: 00 13V, 01 14V, 10 18V, 11 19V
  always @(posedge i_clk)
  begin
    if (rst)
    begin
      o_limit_high <= 2'b00;
      o_tone_force <= 2'b00;
      o_volt_ch1 <= 2'b00;
      o_volt_ch2 <= 2'b00;
    end
    else
    begin
      o_limit_high <= cur_sel; // RULE_01
      o_tone_force <= tone;
      o_volt_ch1 <= {vsel[0] | hvp[0], cable[0]}; // RULE_13
      o_volt_ch2 <= {vsel[1] | hvp[1], cable[1]}; // RULE_13
    end
  end

endmodule // dsc_control

// ### core/dsc_overload.v
`timescale 1ns/1ps
`include "dsc_consts.vh"

module dsc_overload #(
  parameter OFF_CYC = `DSC_OFF_CYC,
  parameter ON_CYC = `DSC_ON_CYC,
  parameter CW = 25
) (
  input wire i_clk,
  input wire i_rst,
  input wire i_enable,
  input wire i_dyn_disable,
  input wire i_overload,
  output reg o_power_on,
  output reg o_flag
);

  localparam [1:0] ST_NORMAL = 2'b00;
  localparam [1:0] ST_OFF = 2'b01;
  localparam [1:0] ST_ON = 2'b10;
  localparam integer OFF_LAST_I = OFF_CYC - 1;
  localparam integer ON_LAST_I = ON_CYC - 1;
  localparam [CW-1:0] OFF_LAST = OFF_LAST_I[CW-1:0];
  localparam [CW-1:0] ON_LAST = ON_LAST_I[CW-1:0];

  reg [1:0] state;
  reg [CW-1:0] count;
  reg seen;
  reg [1:0] next_state;

  always @*
  begin
    next_state = state;
    case (state)
      ST_NORMAL: if (i_overload && !i_dyn_disable) next_state = ST_OFF; // RULE_02
      ST_OFF: if (count == OFF_LAST) next_state = ST_ON; // RULE_04
      ST_ON:
      begin
        if (count == ON_LAST)
          next_state = (seen || i_overload) ? ST_OFF : ST_NORMAL; // RULE_05
      end
      default: next_state = ST_NORMAL;
    endcase
    if (!i_enable || i_dyn_disable)
      next_state = ST_NORMAL;
  end

  // =====================================
  // Retry timer
  always @(posedge i_clk)
  begin
    if (i_rst)
    begin
      state <= ST_NORMAL;
      count <= {CW{1'b0}};
      seen <= 1'b0;
      o_flag <= 1'b0; // RULE_08
      o_power_on <= 1'b0;
    end
    else
    begin
      state <= next_state;
      count <= (next_state != state) ? {CW{1'b0}} : count + 1'b1; // RULE_27
      seen <= (next_state == ST_ON) && (state == ST_ON) && (seen || i_overload);
      o_power_on <= i_enable && (next_state != ST_OFF);
      if (!i_enable)
        o_flag <= 1'b0;
      else if (i_dyn_disable)
        o_flag <= i_overload; // RULE_07
      else if (state == ST_NORMAL && next_state == ST_OFF)
        o_flag <= 1'b1; // RULE_03
      else if (state == ST_ON && next_state == ST_NORMAL)
        o_flag <= 1'b0; // RULE_06
    end
  end

endmodule // dsc_overload

// ### tb/dsc_control_asserts.sv
`timescale 1ns/1ps
// ========================================
// Port checks for the supply controller
module dsc_control_asserts #(
  parameter OFF_CYC = 40,
  parameter ON_CYC = 10
) (
  input wire i_clk,
  input wire i_resetn,
  input wire i_supply_good,
  input wire i_scl,
  input wire i_sda,
  input wire i_addr_strap,
  input wire i_overtemp,
  input wire [1:0] i_overload,
  input wire [1:0] i_high_volt_pin,
  input wire o_sda_out,
  input wire o_sda_oe_n,
  input wire [1:0] o_power_on,
  input wire [1:0] o_limit_high,
  input wire [1:0] o_tone_force,
  input wire [1:0] o_volt_ch1,
  input wire [1:0] o_volt_ch2,
  input wire [7:0] o_channel_one_config,
  input wire [7:0] o_channel_two_config
);
  localparam int OFF_LO = OFF_CYC - 1;
  localparam int OFF_HI = OFF_CYC + 3;
  localparam int ON_LO = ON_CYC - 9;
  localparam int ON_HI = ON_CYC - 5;
  wire [7:0] c1 = o_channel_one_config;
  wire [7:0] c2 = o_channel_two_config;
  reg [31:0] off_cnt;
  // Dark time of channel one, cleared whenever it is powered
  always @(posedge i_clk)
  begin
    if (!i_resetn || o_power_on[0])
      off_cnt <= 32'h0;
    else
      off_cnt <= off_cnt + 32'h1;
  end
  default clocking @(posedge i_clk); endclocking
  default disable iff (!i_resetn);
  // Windows are long enough to cover the input synchronisers
  sequence s_unpowered; (!i_supply_good) [*6]; endsequence
  sequence s_hot; i_overtemp [*6]; endsequence
  sequence s_still; ($stable(c1) && $stable(c2) && $stable(i_high_volt_pin)) [*6]; endsequence
  a_drain_only: assert property (o_sda_out == 1'b0)
    else $error("sda drive value not low");
  a_idle_no_ack: assert property (s_unpowered |-> o_sda_oe_n)
    else $error("sda pulled while unpowered");
  a_idle_regs_zero: assert property (s_unpowered |-> c1 == 8'h00 && c2 == 8'h00)
    else $error("registers not zero while unpowered");
  a_hot_clears: assert property (s_hot |-> (c1 & 8'hFE) == 8'h00 && (c2 & 8'hFC) == 8'h00 && c2[1] && o_power_on == 2'b00)
    else $error("hot state not applied");
  a_limit_sel: assert property (s_still |-> o_limit_high == {c2[6], c1[5]})
    else $error("limit select mismatch");
  a_volt_lift: assert property (s_still |-> o_volt_ch1 == {c1[2] | i_high_volt_pin[0], c1[3]} && o_volt_ch2 == {c2[3] | i_high_volt_pin[1], c2[4]})
    else $error("output level mismatch");
  a_trip_flag: assert property ($fell(o_power_on[0]) && c1[1] && !c1[6] && !i_overtemp |-> ##[0:1] c1[0])
    else $error("trip without flag");
  a_off_length: assert property ($rose(o_power_on[0]) && $past(c1[0]) |-> off_cnt >= OFF_LO && off_cnt <= OFF_HI)
    else $error("off interval length wrong");
  a_retry_window: assert property ($rose(o_power_on[0]) && c1[0] && i_overload[0] |=> o_power_on[0] [*8] ##[ON_LO:ON_HI] !o_power_on[0])
    else $error("on interval wrong");
  a_static_flag: assert property ((c1[6] && c1[1] && !i_overtemp && i_overload[0]) [*6] |-> c1[0] && o_power_on[0])
    else $error("static clamp flag wrong");
  a_low_bit_width: assert property ($fell(o_sda_oe_n) |=> (!o_sda_oe_n) [*5])
    else $error("sda low too short");
endmodule // dsc_control_asserts

bind dsc_control dsc_control_asserts #(.OFF_CYC(OFF_CYC), .ON_CYC(ON_CYC)) u_chk (
  .i_clk(i_clk), .i_resetn(i_resetn), .i_supply_good(i_supply_good), .i_scl(i_scl), .i_sda(i_sda),
  .i_addr_strap(i_addr_strap), .i_overtemp(i_overtemp), .i_overload(i_overload),
  .i_high_volt_pin(i_high_volt_pin), .o_sda_out(o_sda_out), .o_sda_oe_n(o_sda_oe_n),
  .o_power_on(o_power_on), .o_limit_high(o_limit_high), .o_tone_force(o_tone_force),
  .o_volt_ch1(o_volt_ch1), .o_volt_ch2(o_volt_ch2), .o_channel_one_config(o_channel_one_config),
  .o_channel_two_config(o_channel_two_config));

// ### tb/dsc_control_test.sv
`timescale 1ns/1ps
`include "dsc_consts.vh"
// ========================================
// Bench for the supply controller
module dsc_control_test;
  reg clk, resetn, good, strap, hot;
  reg [1:0] ovl, pin;
  wire scl, h_sda, oe_n, sda_out;
  wire [1:0] pwr, lim, tone, v1, v2;
  wire [7:0] c1, c2;
  // Open-drain line with pull-up
  wire sda = h_sda & oe_n;
  reg [31:0] seed;
  reg [7:0] m1, m2, q, adr;
  reg ak;
  integer n_errors, n_compared, i;
  dsc_control #(.OFF_CYC(40), .ON_CYC(10)) dut (
    .i_clk(clk), .i_resetn(resetn), .i_supply_good(good), .i_scl(scl), .i_sda(sda),
    .i_addr_strap(strap), .i_overtemp(hot), .i_overload(ovl), .i_high_volt_pin(pin),
    .o_sda_out(sda_out), .o_sda_oe_n(oe_n), .o_power_on(pwr), .o_limit_high(lim),
    .o_tone_force(tone), .o_volt_ch1(v1), .o_volt_ch2(v2),
    .o_channel_one_config(c1), .o_channel_two_config(c2));
  dsc_host host (.i_clk(clk), .i_sda(sda), .o_scl(scl), .o_sda(h_sda));
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  function [31:0] lfsr(input [31:0] s);
    lfsr = {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction
  task report_and_stop;
  begin
    $display("compared %0d errors %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  end
  endtask
  task chk(input [7:0] seen, input [7:0] exp);
  begin
    n_compared = n_compared + 1;
    if (seen !== exp)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: saw %h want %h", $time, seen, exp);
    end
  end
  endtask
  task wait_pwr(input v, input integer lim_cyc);
    integer k;
  begin
    k = 0;
    while (pwr[0] !== v && k < lim_cyc)
    begin
      @(posedge clk);
      k = k + 1;
    end
    if (pwr[0] !== v)
    begin
      n_errors = n_errors + 1;
      $display("ERROR %0t: power wait ran out", $time);
      report_and_stop;
    end
  end
  endtask
  // Model of the two registers; flag bits stay clear without faults
  task put(input [7:0] d);
    if (d[7])
      m2 = d & 8'hFC;
    else
      m1 = d & 8'hFE;
  endtask
  task wr(input [7:0] a, input [7:0] d0, input [7:0] d1, input ok);
  begin
    host.start;
    host.xfer({a[6:0], 1'b0}, 1'b1, q, ak);
    chk({7'h0, ak}, {7'h0, !ok});
    host.xfer(d0, 1'b1, q, ak);
    chk({7'h0, ak}, {7'h0, !ok});
    host.xfer(d1, 1'b1, q, ak);
    chk({7'h0, ak}, {7'h0, !ok});
    host.stop;
    if (ok)
    begin
      put(d0);
      put(d1);
    end
    chk(c1, m1);
    chk(c2, m2);
  end
  endtask
  task rd;
    integer k;
  begin
    host.start;
    host.xfer({adr[6:0], 1'b1}, 1'b1, q, ak);
    chk({7'h0, ak}, 8'h00);
    for (k = 0; k < 3; k = k + 1)
    begin
      host.xfer(8'hFF, k == 2, q, ak);
      chk(q, k[0] ? m2 : m1);
    end
    host.stop;
  end
  endtask
  task outs;
  begin
    chk({6'h0, lim}, {6'h0, m2[6], m1[5]});
    chk({6'h0, tone}, {6'h0, m2[5], m1[4]});
    chk({6'h0, v1}, {6'h0, m1[2] | pin[0], m1[3]});
    chk({6'h0, v2}, {6'h0, m2[3] | pin[1], m2[4]});
    chk({6'h0, pwr}, {6'h0, m2[2], m1[1]});
  end
  endtask
  initial
  begin
    {resetn, good, strap, hot, ovl, pin} = 8'h40;
    seed = 32'hDF5002F0;
    m1 = 8'h00;
    m2 = 8'h00;
    n_errors = 0;
    n_compared = 0;
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    repeat (4) @(posedge clk);
    chk(c1, 8'h00);
    chk(c2, 8'h00);
    for (i = 0; i < 2; i = i + 1)
    begin
      strap <= i[0];
      repeat (4) @(posedge clk);
      adr = {1'b0, `DSC_ADDR_HI, i[0]};
      wr(adr ^ 8'h01, 8'h7F, 8'hFF, 1'b0);
      wr(adr, 8'h01, 8'h81, 1'b1);
    end
    repeat (16)
    begin
      seed = lfsr(seed);
      pin <= seed[17:16];
      wr(adr, seed[7:0], {~seed[7], seed[14:8]}, 1'b1);
      outs;
      rd;
    end
    pin <= 2'b00;
    wr(adr, 8'h02, 8'h80, 1'b1);
    ovl <= 2'b01;
    wait_pwr(1'b0, 8);
    repeat (2) @(posedge clk);
    chk(c1, 8'h03);
    repeat (30) @(posedge clk);
    chk({6'h0, pwr}, 8'h00);
    wait_pwr(1'b1, 40);
    wait_pwr(1'b0, 20);
    ovl <= 2'b00;
    wait_pwr(1'b1, 60);
    repeat (16) @(posedge clk);
    chk(c1, 8'h02);
    wr(adr, 8'h42, 8'h80, 1'b1);
    ovl <= 2'b01;
    repeat (8) @(posedge clk);
    chk(c1, 8'h43);
    chk({6'h0, pwr}, 8'h01);
    ovl <= 2'b00;
    repeat (8) @(posedge clk);
    chk(c1, 8'h42);
    wr(adr, 8'h02, 8'h80, 1'b1);
    chk({6'h0, pwr}, 8'h01);
    wr(adr, 8'h7C, 8'hFC, 1'b1);
    hot <= 1'b1;
    repeat (8) @(posedge clk);
    chk(c1, 8'h00);
    chk(c2, 8'h02);
    chk({6'h0, pwr}, 8'h00);
    hot <= 1'b0;
    repeat (8) @(posedge clk);
    chk(c2, 8'h00);
    m1 = 8'h00;
    m2 = 8'h00;
    rd;
    pin <= 2'b11;
    wr(adr, 8'h02, 8'h86, 1'b1);
    chk({6'h0, v1}, 8'h02);
    chk({6'h0, v2}, 8'h02);
    pin <= 2'b00;
    m1 = 8'h00;
    m2 = 8'h00;
    good <= 1'b0;
    repeat (8) @(posedge clk);
    wr(adr, 8'h7E, 8'hFC, 1'b0);
    good <= 1'b1;
    repeat (8) @(posedge clk);
    rd;
    report_and_stop;
  end
endmodule // dsc_control_test

// ### tb/dsc_host.sv
`timescale 1ns/1ps
// ========================================
// Bus master model; SCL stands high between frames
module dsc_host (
  input wire i_clk,
  input wire i_sda,
  output reg o_scl,
  output reg o_sda
);
  initial
  begin
    o_scl = 1'b1;
    o_sda = 1'b1;
  end
  task tick(input integer n);
    repeat (n) @(posedge i_clk);
  endtask
  // SDA moves mid-low and is sampled at the end of the high phase
  task bit_xfer(input b, output r);
  begin
    o_scl <= 1'b0;
    tick(2);
    o_sda <= b;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    r = i_sda;
  end
  endtask
  task start;
  begin
    o_scl <= 1'b1;
    o_sda <= 1'b1;
    tick(4);
    o_sda <= 1'b0;
    tick(4);
  end
  endtask
  task stop;
  begin
    o_scl <= 1'b0;
    tick(2);
    o_sda <= 1'b0;
    tick(2);
    o_scl <= 1'b1;
    tick(4);
    o_sda <= 1'b1;
    tick(4);
  end
  endtask
  task xfer(input [7:0] d, input m_ack, output [7:0] q, output ack);
    integer i;
    reg r;
  begin
    for (i = 7; i >= 0; i = i - 1)
    begin
      bit_xfer(d[i], r);
      q[i] = r;
    end
    bit_xfer(m_ack, ack);
  end
  endtask
endmodule // dsc_host
